// file: inc/stc_regs.vh
`ifndef STC_REGS_VH
`define STC_REGS_VH

`define STC_ADDR_W 12
`define STC_DATA_W 8
`define STC_SAMPLE_W 16

`define STC_LINKS 2
`define STC_SUBCH 3
`define STC_PATHS 2
`define STC_SLOTS 16
`define STC_NUM_SAMPLES 192
`define STC_INDEX_W 8
`define STC_BUS_W 3072

`define STC_OFS_CONTROL 12'h032C
`define STC_OFS_EXP_LOW 12'h032D
`define STC_OFS_EXP_HIGH 12'h032E
`define STC_OFS_SELECT 12'h032F
`define STC_OFS_IRQ_STATUS 12'h0330
`define STC_OFS_IRQ_MASK 12'h0331
`define STC_OFS_STATE 12'h0332

`define STC_CTL_ENABLE 0
`define STC_CTL_CLEAR 1
`define STC_CTL_SUBCH_LO 2
`define STC_CTL_SUBCH_HI 3
`define STC_CTL_SLOT_LO 4
`define STC_CTL_SLOT_HI 7

`define STC_SEL_FAIL 0
`define STC_SEL_SPARE_LO 1
`define STC_SEL_SPARE_HI 5
`define STC_SEL_PATH 6
`define STC_SEL_LINK 7

`define STC_IRQ_MISMATCH 0
`define STC_IRQ_MATCH 1

`define STC_SUBCH_MAX 2'h2

`define STC_RST_CONTROL 8'h00
`define STC_RST_EXP_LOW 8'h00
`define STC_RST_EXP_HIGH 8'h00
`define STC_RST_SELECT 8'h00
`define STC_RST_IRQ 8'h00

`endif

// file: rtl/stc_compare.v
`timescale 1ns/1ps
`include "stc_regs.vh"

module stc_compare (
  input wire clk_i,
  input wire sys_rst_i,
  input wire active_i,
  input wire valid_i,
  input wire [`STC_SAMPLE_W-1:0] sample_i,
  input wire [`STC_SAMPLE_W-1:0] expect_i,
  output reg done_o,
  output reg mismatch_o
);

  // One register stage between the wide mux and the result logic keeps the
  // 192-way selection off the flag update path.
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      done_o <= 1'b0;
      mismatch_o <= 1'b0;
    end else begin
      done_o <= active_i & valid_i;
      mismatch_o <= active_i & valid_i & (sample_i != expect_i);
    end
  end

endmodule

// file: rtl/stc_sample_pick.v
`timescale 1ns/1ps
`include "stc_regs.vh"

// Plain multiplexer over the whole receiver output word. The flat bus packs
// samples as ((link * 3 + subchannel) * 2 + path) * 16 + slot.
module stc_sample_pick (
  input wire [`STC_BUS_W-1:0] rx_samples_i,
  input wire [`STC_INDEX_W-1:0] index_i,
  output wire [`STC_SAMPLE_W-1:0] sample_o
);

  wire [`STC_SAMPLE_W-1:0] lane_w [0:`STC_NUM_SAMPLES-1];

  genvar g;
  generate
    for (g = 0; g < `STC_NUM_SAMPLES; g = g + 1) begin : g_lane
      assign lane_w[g] = rx_samples_i[g*`STC_SAMPLE_W +: `STC_SAMPLE_W];
    end
  endgenerate

  // Indices past the last sample cannot occur; the top never forms them.
  assign sample_o = lane_w[index_i];

endmodule

// file: rtl/stc_top.v
`timescale 1ns/1ps
`include "stc_regs.vh"

module stc_top (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [`STC_ADDR_W-1:0] addr_i,
  input wire [`STC_DATA_W-1:0] wr_data_i,
  input wire wr_strobe_i,
  input wire rd_strobe_i,
  output reg [`STC_DATA_W-1:0] rd_data_o,
  input wire [`STC_BUS_W-1:0] rx_samples_i,
  input wire rx_valid_i,
  output reg check_mismatch_flag_o,
  output reg irq_o
);

  // Each qualified receive cycle compares the picked sample with the reference,
  // and a difference sets a sticky fail flag that only the held clear bit removes.
  // From the edge that takes a valid receive cycle, the compare stage registers at
  // that edge, the fail flag and the interrupt status one edge later, and the fail
  // output and the interrupt output two edges later.
  // Selectors are not shadowed: a change while the check is armed takes effect at
  // once, so a sample of a half-written selection can be compared. Software should
  // set them before the enable bit and clear the result before trusting the flag.
  // The trade is a smaller block against that ordering burden on software.

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RUN = 2'b10;

  // Register storage.
  reg [`STC_DATA_W-1:0] control_r;
  reg [`STC_DATA_W-1:0] control_nxt;
  reg [`STC_DATA_W-1:0] expected_low_r;
  reg [`STC_DATA_W-1:0] expected_low_nxt;
  reg [`STC_DATA_W-1:0] expected_high_r;
  reg [`STC_DATA_W-1:0] expected_high_nxt;
  reg check_path_select_r;
  reg check_link_select_r;
  reg [4:0] spare_r;
  reg check_mismatch_flag_r;
  reg check_mismatch_flag_nxt;
  reg [1:0] irq_status_r;
  reg [1:0] irq_mask_r;
  reg [1:0] irq_mask_nxt;
  reg irq_nxt;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg seen_sample_r;
  reg seen_sample_nxt;
  reg [`STC_DATA_W-1:0] rd_data_nxt;

  // Control fields.
  wire check_enable;
  wire check_result_clear;
  wire [1:0] check_subchannel_select;
  wire [3:0] check_slot_select;
  wire subchannel_legal;
  wire compare_active;
  wire [1:0] pick_subchannel;

  // Datapath.
  wire [`STC_SAMPLE_W-1:0] expected_sample;
  wire [`STC_SAMPLE_W-1:0] picked_sample;
  wire [`STC_INDEX_W-1:0] pick_index;
  wire [`STC_INDEX_W-1:0] link_base;
  wire [`STC_INDEX_W-1:0] group_index;
  wire cmp_done;
  wire cmp_mismatch;
  wire mismatch_event;
  wire match_event;

  // Bus decode.
  wire wr_control;
  wire wr_exp_low;
  wire wr_exp_high;
  wire wr_select;
  wire wr_irq_status;
  wire wr_irq_mask;

  assign check_enable = control_r[`STC_CTL_ENABLE];
  assign check_result_clear = control_r[`STC_CTL_CLEAR];
  assign check_subchannel_select = control_r[`STC_CTL_SUBCH_HI:`STC_CTL_SUBCH_LO];
  assign check_slot_select = control_r[`STC_CTL_SLOT_HI:`STC_CTL_SLOT_LO];

  // Code 11 names no subchannel, so no comparison is made with it.
  assign subchannel_legal = (check_subchannel_select <= `STC_SUBCH_MAX);
  assign compare_active = check_enable & subchannel_legal;

  assign expected_sample = {expected_high_r, expected_low_r};

  // Index arithmetic: link * 3 + subchannel gives the channelizer group,
  // then path and slot fill the low bits.
  // Code 11 with link one would index past the last packed sample; the pick then
  // falls back to subchannel zero so the mux never sees an unused index.
  assign pick_subchannel = subchannel_legal ? check_subchannel_select : 2'b00;
  assign link_base = check_link_select_r ? 8'h03 : 8'h00;
  assign group_index = link_base + {6'h00, pick_subchannel};
  assign pick_index = {group_index[2:0], check_path_select_r, check_slot_select};

  assign wr_control = wr_strobe_i & (addr_i == `STC_OFS_CONTROL);
  assign wr_exp_low = wr_strobe_i & (addr_i == `STC_OFS_EXP_LOW);
  assign wr_exp_high = wr_strobe_i & (addr_i == `STC_OFS_EXP_HIGH);
  assign wr_select = wr_strobe_i & (addr_i == `STC_OFS_SELECT);
  assign wr_irq_status = wr_strobe_i & (addr_i == `STC_OFS_IRQ_STATUS);
  assign wr_irq_mask = wr_strobe_i & (addr_i == `STC_OFS_IRQ_MASK);

  stc_sample_pick u_pick (
    .rx_samples_i(rx_samples_i),
    .index_i(pick_index),
    .sample_o(picked_sample)
  );

  stc_compare u_compare (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .active_i(compare_active),
    .valid_i(rx_valid_i),
    .sample_i(picked_sample),
    .expect_i(expected_sample),
    .done_o(cmp_done),
    .mismatch_o(cmp_mismatch)
  );

  // Interrupt events: a mismatch, or a completed comparison that matched. Both
  // follow the compare stage, so they line up with the result flag update.
  assign mismatch_event = cmp_mismatch;
  assign match_event = cmp_done & ~cmp_mismatch;

  // Control register: selectors, clear and enable.
  // The clear bit is a level and keeps the result wiped until it is written back to zero.
  always @* begin
    control_nxt = control_r;
    if (wr_control) begin
      control_nxt = wr_data_i;
    end
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      control_r <= `STC_RST_CONTROL;
    end else begin
      control_r <= control_nxt;
    end
  end

  // Reference sample bytes; the two bytes may be written in either order.
  always @* begin
    expected_low_nxt = expected_low_r;
    expected_high_nxt = expected_high_r;
    if (wr_exp_low) begin
      expected_low_nxt = wr_data_i;
    end
    if (wr_exp_high) begin
      expected_high_nxt = wr_data_i;
    end
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      expected_low_r <= `STC_RST_EXP_LOW;
      expected_high_r <= `STC_RST_EXP_HIGH;
    end else begin
      expected_low_r <= expected_low_nxt;
      expected_high_r <= expected_high_nxt;
    end
  end

  // Link and path selectors share a byte with the read-only result flag.
  // The middle bits are stored so software reads back what it wrote.
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      check_link_select_r <= 1'b0;
      check_path_select_r <= 1'b0;
      spare_r <= 5'h00;
    end else if (wr_select) begin
      check_link_select_r <= wr_data_i[`STC_SEL_LINK];
      check_path_select_r <= wr_data_i[`STC_SEL_PATH];
      spare_r <= wr_data_i[`STC_SEL_SPARE_HI:`STC_SEL_SPARE_LO];
    end
  end

  // Result flag. A held clear bit dominates a mismatch in the same cycle,
  // since the clear is a level that wipes the result for as long as it stands.
  always @* begin
    check_mismatch_flag_nxt = check_mismatch_flag_r;
    if (check_result_clear) begin
      check_mismatch_flag_nxt = 1'b0;
    end else if (cmp_mismatch) begin
      check_mismatch_flag_nxt = 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      check_mismatch_flag_r <= 1'b0;
    end else begin
      check_mismatch_flag_r <= check_mismatch_flag_nxt;
    end
  end

  // Run state: tracks only whether the checker is armed; seen_sample_r records whether a sample was seen.
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (compare_active) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!compare_active) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Remembers that at least one comparison happened since the last clear.
  // Software can then tell a pass that saw no sample from a real pass.
  always @* begin
    seen_sample_nxt = seen_sample_r;
    if (check_result_clear) begin
      seen_sample_nxt = 1'b0;
    end else if (cmp_done) begin
      seen_sample_nxt = 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      seen_sample_r <= 1'b0;
    end else begin
      seen_sample_r <= seen_sample_nxt;
    end
  end

  // Interrupt status: events set sticky bits; writing one clears a bit.
  // A new event in the cycle of its clear keeps the bit set.
  genvar e;
  generate
    for (e = 0; e < 2; e = e + 1) begin : g_irq
      wire event_w;
      if (e == `STC_IRQ_MISMATCH) begin : g_mis
        assign event_w = mismatch_event;
      end else begin : g_match
        assign event_w = match_event;
      end
      always @(posedge clk_i) begin
        if (sys_rst_i) begin
          irq_status_r[e] <= 1'b0;
        end else if (event_w) begin
          irq_status_r[e] <= 1'b1;
        end else if (wr_irq_status & wr_data_i[e]) begin
          irq_status_r[e] <= 1'b0;
        end
      end
    end
  endgenerate

  always @* begin
    irq_mask_nxt = irq_mask_r;
    if (wr_irq_mask) begin
      irq_mask_nxt = wr_data_i[1:0];
    end
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_mask_r <= 2'h0;
    end else begin
      irq_mask_r <= irq_mask_nxt;
    end
  end

  // Read mux; unmapped addresses read zero.
  // The fail flag and the state bits are read-only; writes to them are dropped.
  always @* begin
    rd_data_nxt = 8'h00;
    case (addr_i)
      `STC_OFS_CONTROL: begin
        rd_data_nxt = control_r;
      end
      `STC_OFS_EXP_LOW: begin
        rd_data_nxt = expected_low_r;
      end
      `STC_OFS_EXP_HIGH: begin
        rd_data_nxt = expected_high_r;
      end
      `STC_OFS_SELECT: begin
        rd_data_nxt = {check_link_select_r, check_path_select_r, spare_r, check_mismatch_flag_r};
      end
      `STC_OFS_IRQ_STATUS: begin
        rd_data_nxt = {6'h00, irq_status_r};
      end
      `STC_OFS_IRQ_MASK: begin
        rd_data_nxt = {6'h00, irq_mask_r};
      end
      `STC_OFS_STATE: begin
        rd_data_nxt = {6'h00, seen_sample_r, state_r[1]};
      end
      default: begin
        rd_data_nxt = 8'h00;
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_data_o <= 8'h00;
    end else if (rd_strobe_i) begin
      rd_data_o <= rd_data_nxt;
    end else begin
      rd_data_o <= 8'h00;
    end
  end

  // Level interrupt: high while any status bit that the mask lets through is set.
  // It is registered once more so the pin comes straight from a flip-flop.
  always @* begin
    irq_nxt = |(irq_status_r & irq_mask_r);
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      check_mismatch_flag_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      check_mismatch_flag_o <= check_mismatch_flag_r;
      irq_o <= irq_nxt;
    end
  end

endmodule

// file: testbench/stc_props.sv
`timescale 1ns/1ps
`include "stc_regs.vh"

module stc_props (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [`STC_ADDR_W-1:0] addr_i,
  input wire logic [`STC_DATA_W-1:0] wr_data_i,
  input wire logic wr_strobe_i,
  input wire logic rd_strobe_i,
  input wire logic [`STC_DATA_W-1:0] rd_data_o,
  input wire logic rx_valid_i,
  input wire logic check_mismatch_flag_o,
  input wire logic irq_o
);
  logic [7:0] shd_r [0:5];
  wire arm = rx_valid_i && shd_r[0][0] && shd_r[0][3:2] != 2'b11;
  always @(posedge clk_i) begin
    for (int k = 0; k < 6; k++) begin
      if (sys_rst_i) begin
        shd_r[k] <= 8'h00;
      end else if (wr_strobe_i && addr_i == `STC_OFS_CONTROL + k) begin
        shd_r[k] <= wr_data_i;
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence rd_s(a); rd_strobe_i && addr_i == a; endsequence
  sequence clear_held_s; shd_r[0][1] [*2]; endsequence
  rd_idle_a: assert property (!rd_strobe_i |=> rd_data_o == 8'h00) else $error("read data not idle");
  ctl_read_a: assert property (rd_s(`STC_OFS_CONTROL) |=> rd_data_o == $past(shd_r[0]))
    else $error("control readback wrong");
  low_read_a: assert property (rd_s(`STC_OFS_EXP_LOW) |=> rd_data_o == $past(shd_r[1]))
    else $error("low byte readback wrong");
  high_read_a: assert property (rd_s(`STC_OFS_EXP_HIGH) |=> rd_data_o == $past(shd_r[2]))
    else $error("high byte readback wrong");
  clear_hold_a: assert property (clear_held_s |-> ##2 !check_mismatch_flag_o)
    else $error("flag not cleared");
  armed_rise_a: assert property ($rose(check_mismatch_flag_o) |-> $past(arm, 3) || $past(arm, 4))
    else $error("flag rose without armed sample");
  sticky_fall_a: assert property ($fell(check_mismatch_flag_o) |-> $past(shd_r[0][1], 2) || $past(shd_r[0][1], 3))
    else $error("flag fell without clear");
  irq_mask_a: assert property ($past(shd_r[5]) == 8'h00 |-> !irq_o) else $error("masked interrupt seen");
endmodule

bind stc_top stc_props stc_props_i (.clk_i, .sys_rst_i, .addr_i, .wr_data_i, .wr_strobe_i, .rd_strobe_i,
  .rd_data_o, .rx_valid_i, .check_mismatch_flag_o, .irq_o);

// file: testbench/stc_tx_model.sv
`timescale 1ns/1ps
`include "stc_regs.vh"

// Far-end transmitter model. Every sample other than the chosen one changes each cycle.
// This way a wrong slot pick does not match the expected sample by accident.
module stc_tx_model (
  input wire logic clk_i,
  input wire logic send_i,
  input wire logic [`STC_INDEX_W-1:0] idx_i,
  input wire logic [`STC_SAMPLE_W-1:0] val_i,
  output logic [`STC_BUS_W-1:0] rx_samples_o,
  output logic rx_valid_o
);
  logic [31:0] noise_r = 32'h1357_9bdf;
  initial rx_samples_o = '0;
  initial rx_valid_o = 1'b0;
  always @(posedge clk_i) begin
    noise_r <= {noise_r[30:0], noise_r[31] ^ noise_r[21] ^ noise_r[1] ^ noise_r[0]};
    rx_valid_o <= send_i;
    for (int k = 0; k < `STC_NUM_SAMPLES; k++) begin
      rx_samples_o[k*16+:16] <= noise_r[15:0] ^ k[15:0];
    end
    rx_samples_o[idx_i*16+:16] <= val_i;
  end
endmodule

// file: testbench/tb_top.sv
`timescale 1ns/1ps
`include "stc_regs.vh"

module tb_top;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [11:0] addr_i = 12'h000;
  logic [7:0] wr_data_i = 8'h00;
  logic wr_strobe_i = 1'b0;
  logic rd_strobe_i = 1'b0;
  logic [7:0] rd_data_o;
  logic [`STC_BUS_W-1:0] rx_samples_i;
  logic rx_valid_i;
  logic check_mismatch_flag_o;
  logic irq_o;
  logic send = 1'b0;
  logic [7:0] idx = 8'h00;
  logic [15:0] val = 16'h0000;
  logic [31:0] rnd = 32'h8cb9_0965;
  logic [7:0] sel;
  logic [7:0] iv;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;

  stc_top stc_top_i (.clk_i, .sys_rst_i, .addr_i, .wr_data_i, .wr_strobe_i, .rd_strobe_i, .rd_data_o,
    .rx_samples_i, .rx_valid_i, .check_mismatch_flag_o, .irq_o);
  stc_tx_model stc_tx_model_i (.clk_i, .send_i(send), .idx_i(idx), .val_i(val), .rx_samples_o(rx_samples_i),
    .rx_valid_o(rx_valid_i));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [7:0] pos(input logic lk, input logic [1:0] sc, input logic p, input logic [3:0] sl);
    return 8'(((lk * 3 + sc) * 2 + p) * 16 + sl);
  endfunction

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t read %h expected %h", $time, got, exp);
    end
  endtask
  // Sampled mid-cycle so the edge that updates the output has settled.
  task automatic chk1(input logic exp, input bit irq);
    @(negedge clk_i);
    n_tests++;
    if ((irq ? irq_o : check_mismatch_flag_o) !== exp) begin
      mismatches++;
      $display("[FAIL] %0t output bit wrong", $time);
    end
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    addr_i <= a;
    wr_data_i <= d;
    wr_strobe_i <= 1'b1;
    @(posedge clk_i);
    wr_strobe_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    addr_i <= a;
    rd_strobe_i <= 1'b1;
    @(posedge clk_i);
    rd_strobe_i <= 1'b0;
    #1;
    chk8(rd_data_o, exp);
    @(posedge clk_i);
  endtask
  task automatic push(input logic [7:0] i, input logic [15:0] v);
    idx <= i;
    val <= v;
    send <= 1'b1;
    @(posedge clk_i);
    send <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    for (int a = 12'h32c; a < 12'h334; a++) begin
      rd(a[11:0], 8'h00);
    end
    wr(12'h333, 8'hff);
    rd(12'h333, 8'h00);
    wr(12'h32f, 8'h3f);
    rd(12'h32f, 8'h3e);
    for (int n = 0; n < 12; n++) begin
      rnd = lfsr(rnd);
      if (n == 0) begin
        rnd[9:0] = 10'h3f8;
      end
      if (rnd[3:2] == 2'b11) begin
        rnd[3] = 1'b0;
      end
      sel = {rnd[8], rnd[9], 6'h00};
      iv = pos(rnd[8], rnd[3:2], rnd[9], rnd[7:4]);
      wr(12'h32d, rnd[23:16]);
      wr(12'h32e, rnd[31:24]);
      wr(12'h32f, sel);
      wr(12'h32c, {rnd[7:2], 2'b10});
      wr(12'h32c, {rnd[7:2], 2'b01});
      rd(12'h32c, {rnd[7:2], 2'b01});
      push(iv, rnd[31:16]);
      rd(12'h32f, sel);
      push(iv, rnd[31:16] ^ (16'h0001 << n));
      rd(12'h32f, sel | 8'h01);
      chk1(1'b1, 1'b0);
      push(iv, rnd[31:16]);
      rd(12'h32f, sel | 8'h01);
    end
    wr(12'h32c, 8'h02);
    rd(12'h32f, sel);
    push(iv, ~rnd[31:16]);
    chk1(1'b0, 1'b0);
    wr(12'h32c, {rnd[7:2], 2'b00});
    push(iv, ~rnd[31:16]);
    rd(12'h32f, sel);
    wr(12'h32c, 8'h0d);
    push(iv, ~rnd[31:16]);
    rd(12'h32f, sel);
    rd(12'h330, 8'h03);
    wr(12'h330, 8'hff);
    wr(12'h331, 8'h01);
    wr(12'h32c, {rnd[7:2], 2'b01});
    push(iv, ~rnd[31:16]);
    chk1(1'b1, 1'b1);
    rd(12'h332, 8'h03);
    rd(12'h330, 8'h01);
    wr(12'h330, 8'h01);
    repeat (3) @(posedge clk_i);
    chk1(1'b0, 1'b1);
    end_of_test();
  end
endmodule
